/* File: rtl/hbi_host.sv */
// top: apb-programmed pwm controller driving the gate driver input pins
`timescale 1ns/1ps
module hbi_host (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic first_channel_input,
  output logic second_channel_input,
  output logic output_kill,
  output logic single_input_select,
  output hbi_pkg::hbi_gap_type gap_program_pin,
  output logic [15:0] gap_count
);
  import hbi_pkg::*;
  hbi_state_type s_reg;
  hbi_state_type s_next;
  hbi_chan_if ch_a ();
  hbi_chan_if ch_b ();
  logic addr_ok;
  logic single_mode;
  logic req_a;

  hbi_minw u_minw_a (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ch(ch_a.drv)
  );

  hbi_minw u_minw_b (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ch(ch_b.drv)
  );

  always_comb begin
    case (paddr)
      OFF_CTRL, OFF_PERIOD, OFF_DUTY_A, OFF_B_START, OFF_B_END, OFF_DEADTIME,
      OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign single_mode = (s_reg.mode == MODE_SINGLE_INPUT);

  // channel a: high from the start of the period for duty_a cycles
  assign req_a = s_reg.run && s_reg.en_a && (s_reg.cnt < s_reg.duty_a);
  // a disabled channel, except b in single-input mode, asks for low, so its pin is driven to ground, not left open
  assign ch_a.req = req_a;
  // single-input mode: channel b copies channel a so both pins stay tied together
  assign ch_b.req = single_mode ? req_a :
    (s_reg.run && s_reg.en_b && (s_reg.cnt >= s_reg.b_start) && (s_reg.cnt < s_reg.b_end));

  always_comb begin
    s_next = s_reg;
    if (s_reg.run) begin
      s_next.cnt = (s_reg.cnt >= s_reg.period) ? ZERO16 : s_reg.cnt + 16'h0001;
    end else begin
      s_next.cnt = ZERO16;
    end
    // read data is captured in the setup cycle so prdata comes from a flip-flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_CTRL: s_next.rdata = {24'h000000, s_reg.en_b, s_reg.en_a, s_reg.gap, s_reg.mode,
          s_reg.kill, s_reg.run};
        OFF_PERIOD: s_next.rdata = {16'h0000, s_reg.period};
        OFF_DUTY_A: s_next.rdata = {16'h0000, s_reg.duty_a};
        OFF_B_START: s_next.rdata = {16'h0000, s_reg.b_start};
        OFF_B_END: s_next.rdata = {16'h0000, s_reg.b_end};
        OFF_DEADTIME: s_next.rdata = {16'h0000, s_reg.dt};
        OFF_STATUS: s_next.rdata = {s_reg.cnt, 14'h0000, ch_b.pin, ch_a.pin};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        OFF_CTRL: begin
          s_next.run = pwdata[CTRL_RUN];
          s_next.kill = pwdata[CTRL_KILL];
          s_next.mode = hbi_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
          s_next.gap = hbi_gap_type'(pwdata[CTRL_GAP_LSB +: 2]);
          s_next.en_a = pwdata[CTRL_EN_A];
          s_next.en_b = pwdata[CTRL_EN_B];
        end
        OFF_PERIOD: s_next.period = pwdata[15:0];
        OFF_DUTY_A: s_next.duty_a = pwdata[15:0];
        OFF_B_START: s_next.b_start = pwdata[15:0];
        OFF_B_END: s_next.b_end = pwdata[15:0];
        OFF_DEADTIME: s_next.dt = pwdata[15:0];
        default: s_next.dt = s_reg.dt;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_reg <= '{run: 1'b0, kill: 1'b1, mode: MODE_TWO_INPUT, gap: GAP_PROGRAMMED,
        en_a: 1'b0, en_b: 1'b0, cnt: ZERO16, period: PERIOD_RESET, duty_a: ZERO16,
        b_start: ZERO16, b_end: ZERO16, dt: MIN_DT_CYC, rdata: 32'h00000000};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // zero wait states; a frozen clock enable still answers but changes nothing
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = s_reg.rdata;
  assign first_channel_input = ch_a.pin;
  // both leaves keep their own hold counts, so in single-input mode b mirrors a's pin
  assign second_channel_input = single_mode ? ch_a.pin : ch_b.pin;
  assign output_kill = s_reg.kill;
  assign single_input_select = single_mode;
  assign gap_program_pin = s_reg.gap;
  // a programmed count below the floor is raised, never passed on
  assign gap_count = (s_reg.dt < MIN_DT_CYC) ? MIN_DT_CYC : s_reg.dt;

  a_single_tied: assert property (@(posedge mclk) disable iff (srst)
    single_input_select |-> (first_channel_input == second_channel_input))
    else $error("channel pins differ in single-input mode");
  a_single_select: assert property (@(posedge mclk) disable iff (srst)
    (ce && psel && penable && pwrite && paddr == OFF_CTRL &&
    pwdata[CTRL_MODE_LSB +: 2] == 2'b01) |=> single_input_select)
    else $error("single-input select not raised after mode write");
  a_gap_floor: assert property (@(posedge mclk) disable iff (srst)
    gap_count >= MIN_DT_CYC && (s_reg.dt < MIN_DT_CYC || gap_count == s_reg.dt))
    else $error("dead-time count below floor or not as programmed");
  a_pin_min_high: assert property (@(posedge mclk) disable iff (srst)
    (ce && $rose(first_channel_input)) |-> (first_channel_input || !ce) [*8])
    else $error("channel a pulse shorter than guaranteed width");
  a_unused_low: assert property (@(posedge mclk) disable iff (srst)
    (!s_reg.run && ce) [*8] ##1 (!s_reg.run && ce) [*4] |->
    !first_channel_input && !second_channel_input)
    else $error("stopped controller left a channel pin high");
endmodule : hbi_host

/* File: rtl/hbi_pkg.sv */
// package: register map, field layout, timing counts and state types of the pwm host
package hbi_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_DUTY_A = 8'h08;
  localparam logic [7:0] OFF_B_START = 8'h0C;
  localparam logic [7:0] OFF_B_END = 8'h10;
  localparam logic [7:0] OFF_DEADTIME = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_KILL = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_GAP_LSB = 4;
  localparam int CTRL_EN_A = 6;
  localparam int CTRL_EN_B = 7;
  localparam int STAT_PIN_A = 0;
  localparam int STAT_PIN_B = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [15:0] PERIOD_RESET = 16'h00FF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // shortest pulse the device always reproduces, and shortest legal dead-time
  localparam int MIN_PULSE_NS = 40;
  localparam int MIN_DT_NS = 70;
  localparam logic [7:0] MIN_PULSE_CYC = 8'((MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS);
  localparam logic [15:0] MIN_DT_CYC = 16'((MIN_DT_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS);
  typedef enum logic [1:0] {MODE_TWO_INPUT, MODE_SINGLE_INPUT, MODE_INDEPENDENT, MODE_SPARE}
    hbi_mode_type;
  typedef enum logic [1:0] {GAP_INDEPENDENT, GAP_MINIMAL, GAP_PROGRAMMED, GAP_SPARE}
    hbi_gap_type;
  typedef struct packed {
    logic pin;
    logic [7:0] hold;
  } hbi_minw_state_type;
  typedef struct packed {
    logic run;
    logic kill;
    hbi_mode_type mode;
    hbi_gap_type gap;
    logic en_a;
    logic en_b;
    logic [15:0] cnt;
    logic [15:0] period;
    logic [15:0] duty_a;
    logic [15:0] b_start;
    logic [15:0] b_end;
    logic [15:0] dt;
    logic [31:0] rdata;
  } hbi_state_type;
endpackage : hbi_pkg

/* File: rtl/hbi_chan_if.sv */
// interface: one channel request and the pin level that results from it
`timescale 1ns/1ps
interface hbi_chan_if;
  logic req;
  logic pin;
  modport ctl (output req, input pin);
  modport drv (input req, output pin);
endinterface : hbi_chan_if

/* File: rtl/hbi_minw.sv */
// leaf: follows a channel request but never emits a pulse shorter than the guaranteed width
`timescale 1ns/1ps
module hbi_minw (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  hbi_chan_if.drv ch
);
  import hbi_pkg::*;
  hbi_minw_state_type s_reg;
  hbi_minw_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.hold < MIN_PULSE_CYC) begin
      s_next.hold = s_reg.hold + 8'h01;
    end
    // a level change waits until the current level has stood long enough
    if (ch.req != s_reg.pin && s_reg.hold >= MIN_PULSE_CYC - 8'h01) begin
      s_next.pin = ch.req;
      s_next.hold = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_reg <= '{pin: 1'b0, hold: MIN_PULSE_CYC};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign ch.pin = s_reg.pin;

  // helper: cycles the pin has stood at its level, counted only on enabled cycles
  logic [7:0] chk_len;
  always_ff @(posedge mclk) begin
    if (srst) begin
      chk_len <= MIN_PULSE_CYC;
    end else if (ce) begin
      chk_len <= (s_next.pin != s_reg.pin) ? 8'h01 : ((chk_len < MIN_PULSE_CYC) ?
        chk_len + 8'h01 : chk_len);
    end
  end

  a_pulse_min_width: assert property (@(posedge mclk) disable iff (srst)
    (ce && s_next.pin != s_reg.pin) |-> chk_len >= MIN_PULSE_CYC)
    else $error("pin level stood shorter than the guaranteed width");
  a_idle_low: assert property (@(posedge mclk) disable iff (srst)
    (!ch.req && ce) [*8] ##1 (!ch.req && ce) [*4] |-> !ch.pin)
    else $error("idle channel pin not returned low");
endmodule : hbi_minw

/* File: bench/hbi_drv_model.sv */
// device model: edge re-arm, kill, interlock and dead-time on the gate outputs
`timescale 1ns/1ps
module hbi_drv_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic first_channel_input,
  input wire logic second_channel_input,
  input wire logic output_kill,
  input wire logic single_input_select,
  input wire hbi_pkg::hbi_gap_type gap_program_pin,
  input wire logic [15:0] gap_count,
  output logic first_gate_output,
  output logic second_gate_output
);
  import hbi_pkg::*;
  logic [1:0] eff, prev_reg, arm_reg, out_reg, want, cut;
  logic [15:0] gap_reg, need;
  assign eff = {single_input_select ? ~first_channel_input : second_channel_input,
    first_channel_input};
  assign want = eff & arm_reg;
  // overlap drops both, so neither side can win a tie
  assign cut = want & ~{want[0], want[1]};
  assign need = (gap_program_pin == GAP_PROGRAMMED) ? gap_count : 16'h0001;
  always_ff @(posedge mclk) begin
    prev_reg <= eff;
    if (srst || output_kill) begin
      arm_reg <= 2'h0;
      out_reg <= 2'h0;
      gap_reg <= 16'h0000;
    end else begin
      arm_reg <= arm_reg | (eff & ~prev_reg);
      out_reg <= (gap_program_pin == GAP_INDEPENDENT) ? want :
        cut & (out_reg | ({2{gap_reg >= need}} & ~{out_reg[0], out_reg[1]}));
      gap_reg <= (out_reg != 2'h0) ? 16'h0000 : gap_reg + 16'(gap_reg != 16'hFFFF);
    end
  end
  assign {second_gate_output, first_gate_output} = out_reg;
endmodule : hbi_drv_model

/* File: bench/halfbridge_interlock_deadtime_tb.sv */
// testbench: pwm host over apb, device model on its pins
`timescale 1ns/1ps
module halfbridge_interlock_deadtime_tb;
  import hbi_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pa, pb, kill, sel, ga, gb;
  hbi_gap_type gpin;
  logic [15:0] gcnt, v;
  int failures = 0, check_count = 0, cyc = 0, n;
  hbi_host hbi_host_i (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_channel_input(pa), .second_channel_input(pb),
    .output_kill(kill), .single_input_select(sel), .gap_program_pin(gpin), .gap_count(gcnt));
  hbi_drv_model hbi_drv_model_i (.mclk(mclk), .srst(srst), .first_channel_input(pa),
    .second_channel_input(pb), .output_kill(kill), .single_input_select(sel),
    .gap_program_pin(gpin), .gap_count(gcnt), .first_gate_output(ga), .second_gate_output(gb));
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (++cyc == 20000) begin
      failures++;
      $display("BAD t=%0t timeout", $time);
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // entering on a fresh edge leaves one idle cycle, so no signal is driven twice at once
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic width(input logic ch, input logic [31:0] ctrl, input logic [31:0] exp);
    apb(OFF_CTRL, 1'b1, ctrl);
    while ((ch ? pb : pa) !== 1'b0) @(negedge mclk);
    while ((ch ? pb : pa) !== 1'b1) @(negedge mclk);
    for (n = 0; (ch ? pb : pa) === 1'b1; n++) @(negedge mclk);
    chk(32'(n), exp, "pulse width");
    apb(OFF_CTRL, 1'b1, 32'h20);
  endtask : width
  initial begin
    v = 16'($urandom(32'h49E7));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk(32'({kill, sel, gpin, pa, pb, gcnt}), {10'h0, 6'h28, MIN_DT_CYC}, "reset pins");
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h22, "ctrl reset");
    apb(8'h1C, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 16'(16 + i) : 16'($urandom_range(300));
      apb(OFF_DEADTIME, 1'b1, {16'hA5A5, v});
      apb(OFF_DEADTIME, 1'b0, 32'h0);
      chk(rd, {16'h0, v}, "dead-time readback");
      chk(32'(gcnt), 32'((v < MIN_DT_CYC) ? MIN_DT_CYC : v), "gap count");
    end
    ce <= 1'b0;
    apb(OFF_DEADTIME, 1'b1, 32'h50);
    ce <= 1'b1;
    apb(OFF_DEADTIME, 1'b0, 32'h0);
    chk(rd, {16'h0, v}, "frozen write");
    $display("test dead-time done");
    for (int m = 0; m < 3; m++) begin
      for (int g = 0; g < 3; g++) begin
        apb(OFF_CTRL, 1'b1, 32'(m * 4 + g * 16 + 2));
        repeat (3) @(negedge mclk);
        chk(32'({kill, sel, gpin}), 32'({1'b1, m == 1, 2'(g)}), "mode");
      end
    end
    $display("test modes done");
    apb(OFF_PERIOD, 1'b1, 32'h63);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h3 : 16'($urandom_range(60, 9));
      apb(OFF_DUTY_A, 1'b1, {16'h0, v});
      width(1'b0, 32'h61, (v < 16'hA) ? 32'hA : 32'(v));
    end
    apb(OFF_B_START, 1'b1, 32'h32);
    apb(OFF_B_END, 1'b1, 32'h46);
    width(1'b1, 32'hA1, 32'h14);
    $display("test pulse done");
    apb(OFF_DUTY_A, 1'b1, 32'h1E);
    apb(OFF_CTRL, 1'b1, 32'hE5);
    n = 0;
    for (int i = 0; i < 150; i++) @(negedge mclk) n += int'(pa !== pb);
    chk(32'(n), 32'h0, "single input pins");
    apb(OFF_CTRL, 1'b1, 32'hE7);
    repeat (3) @(negedge mclk);
    chk(32'({kill, ga, gb}), 32'h4, "kill");
    $display("test single and kill done");
    wrap_up();
  end
endmodule : halfbridge_interlock_deadtime_tb
